/* File: rtl/fsru_regs.svh */
// Register selects, field positions, reset values, selector steps, privilege levels and address width for the fast call unit
`ifndef FSRU_REGS_SVH
`define FSRU_REGS_SVH
`define FSRU_SEL_CALL_SELECTOR_TARGET 2'h0
`define FSRU_SEL_LONG_CALL_TARGET 2'h1
`define FSRU_SEL_COMPAT_CALL_TARGET 2'h2
`define FSRU_SEL_FLAGS_CLEAR_MASK 2'h3
`define FSRU_RET_SEL_HI 63
`define FSRU_RET_SEL_LO 48
`define FSRU_ENT_SEL_HI 47
`define FSRU_ENT_SEL_LO 32
`define FSRU_TGT32_HI 31
`define FSRU_TGT32_LO 0
`define FSRU_REG_RESET 64'h0000000000000000
`define FSRU_SS_STEP 16'h0008
`define FSRU_CS64_STEP 16'h0010
`define FSRU_PRIV_USER 2'h3
`define FSRU_PRIV_KERNEL 2'h0
`define FSRU_VA_BITS 48
`endif

/* File: rtl/fsru_pkg.sv */
// Types shared by the fast call unit
package fsru_pkg;
	typedef enum logic [1:0] {
		FSRU_MODE_LEGACY,
		FSRU_MODE_COMPAT,
		FSRU_MODE_64
	} fsru_mode_type;
	typedef struct packed {
		logic [15:0] cs_sel;
		logic [15:0] ss_sel;
		logic [63:0] target;
		logic [63:0] flags;
		logic [1:0] priv;
		logic is_return;
	} fsru_xfer_type;
endpackage

/* File: rtl/fsru_unit.sv */
// Fast operating-system entry and return unit with its four model registers
// Notes on behaviour
// - Return selectors come from bits 63:48
// - Return to 32-bit code: selector unchanged
// - Return to 64-bit code: selector plus 16
// - Return stack selector: field plus 8
// - Entry code selector copied from bits 47:32
// - Entry stack selector: field plus 8
// - Bits 31:0 hold legacy entry target
// - 64-bit caller uses long call target
// - Compatibility caller uses compat call target
// - Non-canonical target write raises protection fault
// - Long-mode entry clears flags under mask
// - Target selector privilege is never checked
// - Return gives level 3, entry level 0
// - Fixed selector and descriptor values, no lookup
// - Model register access privileged, 64-bit wide
`timescale 1ns/1ns
`include "fsru_regs.svh"
module fsru_unit
	import fsru_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Model register access
	input wire logic model_reg_write_i,
	input wire logic model_reg_read_i,
	input wire logic [1:0] reg_sel_i,
	input wire logic [63:0] reg_wdata_i,
	input wire logic [1:0] current_priv_level_i,
	output logic [63:0] reg_rdata_o,
	output logic reg_done_o,
	output logic protection_fault_o,
	// Transfer requests
	input wire logic fast_os_entry_i,
	input wire logic fast_os_return_i,
	input wire logic long_mode_i,
	input wire logic [1:0] caller_mode_i,
	input wire logic [1:0] return_mode_i,
	input wire logic [63:0] flags_word_i,
	// Transfer result
	output logic xfer_valid_o,
	output fsru_xfer_type xfer_o
);

	logic rst_meta_ff;
	logic rst_sync_ff;
	logic [63:0] call_selector_target_ff;
	logic [63:0] long_call_target_ff;
	logic [63:0] compat_call_target_ff;
	logic [63:0] flags_clear_mask_ff;
	logic [63:0] nxt_call_selector_target;
	logic [63:0] nxt_long_call_target;
	logic [63:0] nxt_compat_call_target;
	logic [63:0] nxt_flags_clear_mask;
	logic [63:0] rdata_ff;
	logic [63:0] nxt_rdata;
	logic done_ff;
	logic nxt_done;
	logic fault_ff;
	logic nxt_fault;
	logic xvalid_ff;
	logic nxt_xvalid;
	fsru_xfer_type xfer_ff;
	fsru_xfer_type nxt_xfer;
	logic [15:0] ret_field;
	logic [15:0] ent_field;

	// Canonical when bits above the VA width copy the top VA bit
	function automatic logic is_canonical(input logic [63:0] a);
		logic [63:0] ext;
		ext = {{(64 - `FSRU_VA_BITS){a[`FSRU_VA_BITS - 1]}},
			a[`FSRU_VA_BITS - 1:0]};
		is_canonical = (ext == a);
	endfunction

	// Reset release through two flops, assertion stays asynchronous
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	assign ret_field = call_selector_target_ff[`FSRU_RET_SEL_HI:`FSRU_RET_SEL_LO];
	assign ent_field = call_selector_target_ff[`FSRU_ENT_SEL_HI:`FSRU_ENT_SEL_LO];

	// Register access; only level 0 may touch the registers
	always_comb begin
		nxt_call_selector_target = call_selector_target_ff;
		nxt_long_call_target = long_call_target_ff;
		nxt_compat_call_target = compat_call_target_ff;
		nxt_flags_clear_mask = flags_clear_mask_ff;
		nxt_rdata = rdata_ff;
		nxt_done = 1'b0;
		nxt_fault = 1'b0;
		if (model_reg_write_i || model_reg_read_i) begin
			nxt_done = 1'b1;
			if (current_priv_level_i != `FSRU_PRIV_KERNEL) begin
				nxt_fault = 1'b1;
			end else if (model_reg_write_i) begin
				case (reg_sel_i)
				`FSRU_SEL_CALL_SELECTOR_TARGET: begin
					nxt_call_selector_target = reg_wdata_i;
				end
				`FSRU_SEL_LONG_CALL_TARGET: begin
					// Faulting write leaves the old target in place
					if (is_canonical(reg_wdata_i)) begin
						nxt_long_call_target = reg_wdata_i;
					end else begin
						nxt_fault = 1'b1;
					end
				end
				`FSRU_SEL_COMPAT_CALL_TARGET: begin
					if (is_canonical(reg_wdata_i)) begin
						nxt_compat_call_target = reg_wdata_i;
					end else begin
						nxt_fault = 1'b1;
					end
				end
				default: begin
					nxt_flags_clear_mask = reg_wdata_i;
				end
				endcase
			end else begin
				case (reg_sel_i)
				`FSRU_SEL_CALL_SELECTOR_TARGET: nxt_rdata = call_selector_target_ff;
				`FSRU_SEL_LONG_CALL_TARGET: nxt_rdata = long_call_target_ff;
				`FSRU_SEL_COMPAT_CALL_TARGET: nxt_rdata = compat_call_target_ff;
				default: nxt_rdata = flags_clear_mask_ff;
				endcase
			end
		end
	end

	// Register file, cleared at reset
	always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			call_selector_target_ff <= `FSRU_REG_RESET;
			long_call_target_ff <= `FSRU_REG_RESET;
			compat_call_target_ff <= `FSRU_REG_RESET;
			flags_clear_mask_ff <= `FSRU_REG_RESET;
			rdata_ff <= 64'h0;
			done_ff <= 1'b0;
			fault_ff <= 1'b0;
		end else begin
			call_selector_target_ff <= nxt_call_selector_target;
			long_call_target_ff <= nxt_long_call_target;
			compat_call_target_ff <= nxt_compat_call_target;
			flags_clear_mask_ff <= nxt_flags_clear_mask;
			rdata_ff <= nxt_rdata;
			done_ff <= nxt_done;
			fault_ff <= nxt_fault;
		end
	end

	// Transfer builder: fixed selectors, no table walk, no privilege check
	always_comb begin
		nxt_xfer = xfer_ff;
		nxt_xvalid = 1'b0;
		if (fast_os_return_i) begin
			nxt_xvalid = 1'b1;
			nxt_xfer.is_return = 1'b1;
			if (return_mode_i == FSRU_MODE_64) begin
				nxt_xfer.cs_sel = ret_field + `FSRU_CS64_STEP;
			end else begin
				nxt_xfer.cs_sel = ret_field;
			end
			nxt_xfer.ss_sel = ret_field + `FSRU_SS_STEP;
			nxt_xfer.priv = `FSRU_PRIV_USER;
			nxt_xfer.target = 64'h0;
			nxt_xfer.flags = flags_word_i;
		end else if (fast_os_entry_i) begin
			nxt_xvalid = 1'b1;
			nxt_xfer.is_return = 1'b0;
			nxt_xfer.cs_sel = ent_field;
			nxt_xfer.ss_sel = ent_field + `FSRU_SS_STEP;
			nxt_xfer.priv = `FSRU_PRIV_KERNEL;
			if (!long_mode_i) begin
				nxt_xfer.target = {32'h0,
					call_selector_target_ff[`FSRU_TGT32_HI:`FSRU_TGT32_LO]};
				nxt_xfer.flags = flags_word_i;
			end else begin
				if (caller_mode_i == FSRU_MODE_64) begin
					nxt_xfer.target = long_call_target_ff;
				end else begin
					nxt_xfer.target = compat_call_target_ff;
				end
				nxt_xfer.flags = flags_word_i & ~flags_clear_mask_ff;
			end
		end
	end

	// Transfer result registers
	always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			xfer_ff <= '0;
			xvalid_ff <= 1'b0;
		end else begin
			xfer_ff <= nxt_xfer;
			xvalid_ff <= nxt_xvalid;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign reg_done_o = done_ff;
	assign protection_fault_o = fault_ff;
	assign xfer_valid_o = xvalid_ff;
	assign xfer_o = xfer_ff;

	// All checks share the core clock and the synchronised reset
	default clocking fsru_cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_sync_ff);

	// Return code selector tracks the target mode
	a_ret_cs_sel: assert property (
		fast_os_return_i |=> xfer_o.cs_sel ==
		(($past(return_mode_i) == FSRU_MODE_64) ?
		$past(ret_field) + 16'h0010 : $past(ret_field)))
		else $error("return code selector wrong");

	// Stack selector is one descriptor above, any mode
	a_ret_ss_sel: assert property (
		fast_os_return_i |=> xfer_o.ss_sel == $past(ret_field) + 16'h0008)
		else $error("return stack selector wrong");

	// Entry selectors come straight from the entry field
	a_ent_sel: assert property (
		(fast_os_entry_i && !fast_os_return_i) |=>
		xfer_o.cs_sel == $past(ent_field)
		&& xfer_o.ss_sel == $past(ent_field) + 16'h0008)
		else $error("entry selectors wrong");

	// Privilege is forced, never taken from the selectors
	a_priv_level: assert property (
		xfer_valid_o |-> xfer_o.priv == (xfer_o.is_return ? 2'h3 : 2'h0))
		else $error("privilege level wrong");

	// Each request cycle yields exactly one result, one cycle later; a return wins over a same-cycle entry
	a_xfer_pulse: assert property (
		(fast_os_entry_i || fast_os_return_i) |=> xfer_valid_o
		&& xfer_o.is_return == $past(fast_os_return_i))
		else $error("transfer result missing");

	// Masked bits cleared, the rest kept
	a_flag_mask: assert property (
		(fast_os_entry_i && !fast_os_return_i && long_mode_i) |=>
		xfer_o.flags == ($past(flags_word_i) & ~$past(flags_clear_mask_ff)))
		else $error("masked flag survived");

	// Long mode target choice follows the caller's mode
	a_long_target: assert property (
		(fast_os_entry_i && !fast_os_return_i && long_mode_i
		&& caller_mode_i == FSRU_MODE_64) |=>
		xfer_o.target == $past(long_call_target_ff))
		else $error("long target wrong");

	a_compat_target: assert property (
		(fast_os_entry_i && !fast_os_return_i && long_mode_i
		&& caller_mode_i != FSRU_MODE_64) |=>
		xfer_o.target == $past(compat_call_target_ff))
		else $error("compat target wrong");

	// Outside long mode only the 32-bit field is used
	a_legacy_target: assert property (
		(fast_os_entry_i && !fast_os_return_i && !long_mode_i) |=>
		xfer_o.target == {32'h0, $past(call_selector_target_ff[31:0])})
		else $error("legacy target wrong");

	// A refused target write must not disturb either target
	a_noncanon_fault: assert property (
		(model_reg_write_i && (reg_sel_i == 2'h1 || reg_sel_i == 2'h2)
		&& current_priv_level_i == 2'h0 && !is_canonical(reg_wdata_i))
		|=> protection_fault_o && $stable(long_call_target_ff)
		&& $stable(compat_call_target_ff))
		else $error("non-canonical write accepted");

	a_user_fault: assert property (
		(model_reg_write_i && current_priv_level_i != 2'h0) |=>
		protection_fault_o && $stable(call_selector_target_ff)
		&& $stable(flags_clear_mask_ff))
		else $error("unprivileged write accepted");

	// Every access is answered in the next cycle
	a_done_pulse: assert property (
		(model_reg_write_i || model_reg_read_i) |=> reg_done_o)
		else $error("access not answered");

	// A granted read returns the whole register
	a_read_data: assert property (
		(model_reg_read_i && !model_reg_write_i && reg_sel_i == 2'h0
		&& current_priv_level_i == 2'h0) |=>
		reg_rdata_o == $past(call_selector_target_ff))
		else $error("read data wrong");

endmodule

/* File: test/tb.sv */
// Self-checking bench for the fast call unit
`timescale 1ns/1ns
`include "fsru_regs.svh"
module tb;
	import fsru_pkg::*;
	logic clk, rst_n, wr, rd, ent, ret, lm, done, fault, xv, l;
	logic [1:0] sel, priv, cmode, rmode, s2;
	logic [63:0] wdata, flags, rdata, last_rd, d;
	logic [63:0] regs [4];
	fsru_xfer_type xo;
	int bad_count, comparisons, seed;

	fsru_unit fsru_unit_i (.core_clk_i(clk), .reset_n_i(rst_n),
		.model_reg_write_i(wr), .model_reg_read_i(rd), .reg_sel_i(sel),
		.reg_wdata_i(wdata), .current_priv_level_i(priv),
		.reg_rdata_o(rdata), .reg_done_o(done), .protection_fault_o(fault),
		.fast_os_entry_i(ent), .fast_os_return_i(ret), .long_mode_i(lm),
		.caller_mode_i(cmode), .return_mode_i(rmode), .flags_word_i(flags),
		.xfer_valid_o(xv), .xfer_o(xo));

	// Free-running core clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic test_done;
		if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Wide compare so a whole transfer record fits in one call
	task automatic chk(input logic [191:0] got, input logic [191:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic canon(input logic [63:0] v);
		return (&v[63:47]) | ~(|v[63:47]);
	endfunction

	// One register access; refused reads must leave old read data
	task automatic acc(input logic w, input logic [1:0] s,
		input logic [63:0] dv, input logic [1:0] p);
		logic ok;
		@(negedge clk);
		wr = w; rd = !w; sel = s; wdata = dv; priv = p;
		ok = (p == 2'h0) && !(w && (s == 2'h1 || s == 2'h2) && !canon(dv));
		@(negedge clk);
		chk({done, fault}, {1'b1, !ok});
		if (w && ok) regs[s] = dv;
		if (!w && ok) last_rd = regs[s];
		if (!w) chk(rdata, last_rd);
		wr = 1'b0; rd = 1'b0;
	endtask

	// One entry or return, expectation built from the shadow registers
	task automatic xfer(input logic r, input logic lv, input logic [1:0] cm,
		input logic [1:0] rm, input logic [63:0] f);
		fsru_xfer_type e;
		logic [63:0] s;
		s = regs[0];
		@(negedge clk);
		ent = !r; ret = r; lm = lv; cmode = cm; rmode = rm; flags = f;
		e.ss_sel = (r ? s[63:48] : s[47:32]) + `FSRU_SS_STEP;
		e.is_return = r;
		if (r) begin
			e.cs_sel = (rm == 2'h2) ? s[63:48] + `FSRU_CS64_STEP : s[63:48];
			e.target = 64'h0;
			e.flags = f;
			e.priv = 2'h3;
		end else begin
			e.cs_sel = s[47:32];
			e.target = !lv ? {32'h0, s[31:0]} :
				(cm == 2'h2 ? regs[1] : regs[2]);
			e.flags = lv ? (f & ~regs[3]) : f;
			e.priv = 2'h0;
		end
		@(negedge clk);
		chk({xv, xo}, {1'b1, e});
		ent = 1'b0; ret = 1'b0;
	endtask

	// Hang guard, far beyond the expected run length
	initial begin
		#100000;
		bad_count++;
		test_done;
	end

	initial begin
		rst_n = 1'b0; wr = 1'b0; rd = 1'b0; ent = 1'b0; ret = 1'b0;
		lm = 1'b0; sel = 2'h0; priv = 2'h0; cmode = 2'h0; rmode = 2'h0;
		wdata = 64'h0; flags = 64'h0; last_rd = 64'h0; d = 64'h0;
		l = 1'b0; s2 = 2'h0; bad_count = 0; comparisons = 0;
		for (int i = 0; i < 4; i++) regs[i] = 64'h0;
		seed = $urandom(32'hbe25);
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 4; i++) acc(1'b0, 2'(i), 64'h0, 2'h0);
		// Corner cases: canonical boundary and privilege refusal
		acc(1'b1, 2'h1, 64'h0000_8000_0000_0000, 2'h0);
		acc(1'b1, 2'h2, 64'hffff_7fff_ffff_ffff, 2'h0);
		acc(1'b1, 2'h2, 64'hffff_8000_0000_0000, 2'h0);
		acc(1'b1, 2'h0, 64'h1234_5678_9abc_def0, 2'h3);
		acc(1'b0, 2'h2, 64'h0, 2'h1);
		acc(1'b1, 2'h0, 64'hfff3_0000_1234_5678, 2'h0);
		xfer(1'b1, 1'b1, 2'h2, 2'h2, 64'h0);
		xfer(1'b0, 1'b0, 2'h0, 2'h0, 64'hffff_ffff_ffff_ffff);
		// Random mix of accesses and transfers
		for (int i = 0; i < 400; i++) begin
			d = {$urandom, $urandom};
			if ($urandom_range(1, 0) == 1) d[63:47] = {17{d[47]}};
			s2 = 2'($urandom_range(3, 0));
			l = 1'($urandom_range(1, 0));
			case ($urandom_range(3, 0))
				0: acc(1'b1, s2, d, ($urandom_range(5, 0) == 0) ? 2'h2 : 2'h0);
				1: acc(1'b0, s2, 64'h0, ($urandom_range(5, 0) == 0) ? 2'h3 : 2'h0);
				2: xfer(1'b0, l, l ? 2'($urandom_range(2, 1)) : 2'h0, 2'h0, d);
				default: xfer(1'b1, l, 2'h0, s2, d);
			endcase
		end
		test_done;
	end
endmodule
